// [core/tsr4_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] Four bits share one clock, update together
// [R2] Either output disable floats all outputs
// [R3] Either data disable recirculates stored word
// [R4] Master reset clears word at once, asynchronously
// [R5] Only parallel load or hold on edges
// [R6] Output disables leave flip-flop operation untouched
// [R7] Rising edge updates; steady between edges
//////////////////////////////////////////////////////////////////////////////
package tsr4_pkg;

    localparam int          TSR4_WIDTH       = 4;
    localparam int          TSR4_ADDR_W      = 4;
    localparam int          TSR4_BUS_W       = 32;

    // Byte offsets of the software registers
    localparam logic [3:0]  TSR4_CTRL_OFS    = 4'h0;
    localparam logic [3:0]  TSR4_STATUS_OFS  = 4'h4;

    // Control register fields
    localparam int          TSR4_CTRL_DDIS   = 0;
    localparam int          TSR4_CTRL_ODIS   = 1;
    localparam int          TSR4_CTRL_W      = 2;
    localparam logic [1:0]  TSR4_CTRL_RST    = 2'h0;

    // Status register fields
    localparam int          TSR4_STAT_WORD   = 0;
    localparam int          TSR4_STAT_OE     = 4;
    localparam int          TSR4_STAT_HOLD   = 5;

    localparam logic [3:0]  TSR4_WORD_RST    = 4'h0;

endpackage : tsr4_pkg

// [core/tsr4_bit.sv]
module tsr4_bit
    import tsr4_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic clr_n,
    input  wire logic hold,
    input  wire logic d,
    output logic      q
);

    // Feedback mux keeps the clock running while the bit holds
    logic next_q;

    always_comb begin
        next_q = hold ? q : d; // R3
    end

    always_ff @(posedge core_clk or negedge clr_n) begin
        if (!clr_n) begin
            q <= 1'b0; // R4
        end else begin
            q <= next_q; // R7
        end
    end

endmodule : tsr4_bit

// [core/tsr4_reg.sv]
module tsr4_reg
    import tsr4_pkg::*;
#(
    parameter int WIDTH = TSR4_WIDTH
)
(
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic [WIDTH-1:0]       data_in,
    input  wire logic                   data_dis_a,
    input  wire logic                   data_dis_b,
    input  wire logic                   out_dis_a,
    input  wire logic                   out_dis_b,
    input  wire logic                   master_reset,
    output logic      [WIDTH-1:0]       q_out,
    output logic                        q_oe_n,
    input  wire logic [TSR4_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [TSR4_BUS_W-1:0]  avs_writedata,
    output logic      [TSR4_BUS_W-1:0]  avs_readdata,
    output logic                        avs_waitrequest
);

    //////////////////////////////////////////////////////////////////////////
    // Reset release

    logic       rst_meta_n;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control gating

    logic [TSR4_CTRL_W-1:0] ctrl;
    logic                   hold;
    logic                   load;
    logic                   clr_n;
    logic [WIDTH-1:0]       word;

    // OR-gated disables; software bits join the pin pair
    assign hold   = data_dis_a | data_dis_b | ctrl[TSR4_CTRL_DDIS]; // R3 R5
    assign load   = ~hold; // R5
    assign q_oe_n = out_dis_a | out_dis_b | ctrl[TSR4_CTRL_ODIS]; // R2

    // Master reset bypasses the clock entirely
    assign clr_n  = rst_n & ~master_reset; // R4

    //////////////////////////////////////////////////////////////////////////
    // Storage, one cell per bit on the shared clock

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit // R1
        tsr4_bit u_bit (
            .core_clk (core_clk),
            .clr_n    (clr_n),
            .hold     (hold),
            .d        (data_in[i]),
            .q        (word[i])
        );
    end

    // Word drives the pins regardless of enable; disables touch only q_oe_n
    assign q_out = word; // R6

    //////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait cycle per access

    logic                  ack;
    logic                  req;
    logic                  ctrl_hit;
    logic                  stat_hit;
    logic [TSR4_BUS_W-1:0] next_rdata;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign ctrl_hit        = (avs_address == TSR4_CTRL_OFS);
    assign stat_hit        = (avs_address == TSR4_STATUS_OFS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= TSR4_CTRL_RST;
        end else if (avs_write && ack && ctrl_hit) begin
            ctrl <= avs_writedata[TSR4_CTRL_W-1:0];
        end
    end

    always_comb begin
        next_rdata = '0;
        if (ctrl_hit) begin
            next_rdata[TSR4_CTRL_W-1:0] = ctrl;
        end else if (stat_hit) begin
            next_rdata[TSR4_STAT_WORD +: TSR4_WIDTH] = word[TSR4_WIDTH-1:0];
            next_rdata[TSR4_STAT_OE]                 = ~q_oe_n;
            next_rdata[TSR4_STAT_HOLD]               = hold;
        end
    end

    // Captured in the wait cycle so data stand at the completing edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks

    logic [WIDTH-1:0] word_mid;

    // Mid-cycle snapshot to prove the word is steady between edges
    always_ff @(negedge core_clk or negedge clr_n) begin
        if (!clr_n) begin
            word_mid <= '0;
        end else begin
            word_mid <= word;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rst_n || master_reset);

    AST_LOAD_WORD: assert property ( // R1
        load |=> word == $past(data_in)
    ) else $error("word did not load all bits together");

    AST_OUT_FLOAT: assert property ( // R2
        (out_dis_a || out_dis_b) |-> q_oe_n
    ) else $error("outputs driven while an output disable is high");

    AST_OUT_DRIVE: assert property ( // R2
        (!out_dis_a && !out_dis_b && !ctrl[TSR4_CTRL_ODIS]) |-> !q_oe_n
    ) else $error("outputs floated with no disable high");

    AST_HOLD_STABLE: assert property ( // R3
        (data_dis_a || data_dis_b) |=> word == $past(word)
    ) else $error("word changed while a data disable was high");

    AST_MASTER_CLEAR: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_n)
        master_reset |-> word == TSR4_WORD_RST
    ) else $error("master reset did not clear the word");

    AST_ONLY_TWO_MODES: assert property ( // R5
        (word != $past(word)) |-> $past(load)
    ) else $error("word changed without a parallel load");

    AST_OE_NO_EFFECT: assert property ( // R6
        (q_oe_n && load) ##1 !master_reset |-> word == $past(data_in)
    ) else $error("output disable disturbed loading");

    AST_STEADY_BETWEEN: assert property ( // R7
        word == word_mid
    ) else $error("word moved between rising edges");

    AST_BUS_ONE_WAIT: assert property (
        (req && !ack) |-> avs_waitrequest ##1 (!req || !avs_waitrequest)
    ) else $error("bus access not answered after one wait cycle");

    //////////////////////////////////////////////////////////////////////////
    // Software path and master reset release checks

    AST_OE_SOFT: assert property ( // R2
        ctrl[TSR4_CTRL_ODIS] |-> q_oe_n
    ) else $error("outputs driven while the software disable is set");

    AST_HOLD_SOFT: assert property ( // R3
        ctrl[TSR4_CTRL_DDIS] |=> word == $past(word)
    ) else $error("word changed while the software hold was set");

    AST_CLEAR_RELEASE: assert property ( // R4
        $fell(master_reset) |-> word == TSR4_WORD_RST
    ) else $error("word not clear at the edge after master reset");

    AST_STATUS_WORD: assert property ( // R6
        (avs_read && avs_waitrequest && stat_hit)
        |=> avs_readdata[TSR4_STAT_WORD +: TSR4_WIDTH] == $past(word[TSR4_WIDTH-1:0])
    ) else $error("status read did not return the stored word");

    AST_STATUS_OE: assert property ( // R2
        (avs_read && avs_waitrequest && stat_hit)
        |=> avs_readdata[TSR4_STAT_OE] == !$past(q_oe_n)
    ) else $error("status read misreported the output enable");

    AST_CTRL_LOAD: assert property (
        (avs_write && !avs_waitrequest && ctrl_hit)
        |=> ctrl == $past(avs_writedata[TSR4_CTRL_W-1:0])
    ) else $error("control write did not land");

    AST_CTRL_IGNORE: assert property (
        (avs_write && !ctrl_hit) |=> $stable(ctrl)
    ) else $error("write outside the control register changed it");

    AST_RDATA_UNMAPPED: assert property (
        (avs_read && avs_waitrequest && !ctrl_hit && !stat_hit) |=> avs_readdata == '0
    ) else $error("read of an unmapped offset returned nonzero data");

    AST_WAIT_IDLE: assert property (
        !req |-> !avs_waitrequest
    ) else $error("waitrequest raised with no access pending");

    COV_LOAD_HIDDEN: cover property (q_oe_n && load ##1 word != $past(word));
    COV_HOLD_RUN:    cover property (hold [*4]);
    COV_CLEAR:       cover property (@(posedge core_clk) disable iff (!rst_n)
                                     $rose(master_reset));
    COV_CTRL_WRITE:  cover property (avs_write && ack && ctrl_hit);
    COV_STAT_READ:   cover property (avs_read && ack && stat_hit);

endmodule : tsr4_reg

// [test/tsr4_bus_model.sv]
module tsr4_bus_model
    import tsr4_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic [TSR4_WIDTH-1:0] q_out,
    input  wire logic                  q_oe_n,
    output logic      [TSR4_WIDTH-1:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [TSR4_WIDTH-1:0] last = 4'h0;
    // Released lines flip each cycle so stale data never passes
    always @(posedge core_clk) begin
        last <= bus;
    end
    assign bus = q_oe_n ? ~last : q_out;
endmodule : tsr4_bus_model

// [test/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tsr4_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b1;
    logic [3:0]  data_in  = 4'h0;
    logic [4:0]  ctl      = 5'h00;
    logic [3:0]  addr     = 4'h0;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic [3:0]  q_out;
    logic [3:0]  bus;
    logic        q_oe_n;
    logic        wait_req;
    int          num_errors   = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    // Rows: data, {reset, od_b, od_a, dd_b, dd_a}, word, oe_n
    logic [3:0]  t_d [8] = '{4'hA, 4'h5, 4'h3, 4'hC, 4'h6, 4'h6, 4'h9, 4'h9};
    logic [4:0]  t_c [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h13, 5'h00, 5'h00};
    logic [3:0]  t_q [8] = '{4'h0, 4'hA, 4'hA, 4'hA, 4'hC, 4'h0, 4'h0, 4'h9};
    logic        t_o [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    always #20 core_clk = ~core_clk;

    tsr4_reg dut (
        .core_clk(core_clk), .nrst(nrst), .data_in(data_in),
        .data_dis_a(ctl[0]), .data_dis_b(ctl[1]), .out_dis_a(ctl[2]),
        .out_dis_b(ctl[3]), .master_reset(ctl[4]), .q_out(q_out),
        .q_oe_n(q_oe_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_req)
    );
    tsr4_bus_model far (.core_clk(core_clk), .q_out(q_out), .q_oe_n(q_oe_n), .bus(bus));

    //////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Request stands until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        do begin
            @(posedge core_clk);
        end while (wait_req !== 1'b0);
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // Settle before callers look at outputs
        @(negedge core_clk);
    endtask : xfer

    task automatic step(input logic [3:0] d, input logic [4:0] c);
        @(posedge core_clk);
        data_in <= d;
        ctl     <= c;
        @(negedge core_clk);
    endtask : step

    //////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        // Falls at time zero from its initial 1 so the reset flops see a real edge
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            step(t_d[i], t_c[i]);
            chk("q_out", 32'(t_q[i]), 32'(q_out));
            chk("q_oe_n", 32'(t_o[i]), 32'(q_oe_n));
            if (!t_o[i]) chk("bus", 32'(t_q[i]), 32'(bus));
        end
        xfer(1'b1, TSR4_CTRL_OFS, 32'h1);
        step(4'hF, 5'h00);
        step(4'hF, 5'h00);
        chk("q_out", 32'h9, 32'(q_out));
        xfer(1'b0, TSR4_STATUS_OFS, 32'h0);
        chk("status", 32'h39, rv);
        xfer(1'b1, TSR4_CTRL_OFS, 32'h2);
        chk("q_oe_n", 32'h1, 32'(q_oe_n));
        xfer(1'b0, TSR4_STATUS_OFS, 32'h0);
        chk("status", 32'h0F, rv);
        xfer(1'b1, 4'h8, 32'h3);
        xfer(1'b0, 4'h8, 32'h0);
        chk("unmapped", 32'h0, rv);
        xfer(1'b0, TSR4_CTRL_OFS, 32'h0);
        chk("ctrl", 32'h2, rv);
        report_and_stop();
    end
endmodule : testbench
